// [logic/nvm_port_pkg.sv]
// Constants, types and command codes of the parallel programming port.
// Assumes a 100 MHz reference clock and pins driven by an outside programmer.
// Summary of operation
// - A strap change within 100 ns of voltage rise refuses entry.
// - Dropping the programming voltage leaves the mode; re-enter normally.
// - Loaded command and address persist across operations.
// - Address high byte holds until reloaded.
// - Chip erase clears flash, EEPROM, then locks; fuses kept.
// - Keep-EEPROM fuse programmed means chip erase spares the EEPROM.
// - Action 10 with select A low loads a command; 80 erases.
// - Action 00 loads address low or high byte by select A.
// - Action 01 loads data low or high byte by select A.
// - Page-latch pulse with select A high stores data in the page buffer.
// - Low address bits pick the word, upper bits pick the page.
// - Command 10 accepts repeated address, data and latch steps.
// - Write strobe with select A low programs the page; ready low meanwhile.
// - Command 00 is a no-op and disarms page writing.
// - Command 11 writes the EEPROM page the same way.
// - Command 02 with output enable low reads a flash byte.
// - Command 03 with output enable low reads an EEPROM byte.
// - Command 40 writes fuses from data low; zero programs a fuse.
// - Byte selects pick low, high or extended fuse byte.
// - Ready flag is low while busy and high when idle.
package nvm_port_pkg;
   localparam int CLK_NS          = 10;
   localparam int STRAP_HOLD_NS   = 100;
   localparam int STRAP_HOLD_CYC  = (STRAP_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_NS        = 3700000;
   localparam int WRITE_CYC       = (WRITE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_NS        = 7500000;
   localparam int ERASE_CYC       = (ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] ENTRY_TOGGLES = 3'h6;
   localparam logic [3:0] STRAPS_ENTRY  = 4'h0;

   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;

   localparam logic [7:0] CMD_NOP      = 8'h00;
   localparam logic [7:0] CMD_ERASE    = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE    = 8'h11;
   localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE    = 8'h03;

   localparam logic [7:0] ERASED_BYTE  = 8'hFF;
   localparam logic [7:0] FUSE_LO_RST  = 8'hE1;
   localparam logic [7:0] LOCK_RST     = 8'hFF;
   localparam int         KEEP_EE_BIT  = 3;

   typedef struct packed {
      logic [1:0] action;
      logic       bsa;
      logic [7:0] data;
   } load_word_t;

   typedef struct packed {
      logic oe_n;
      logic wr_n;
      logic page_latch_strobe;
      logic byte_select_b;
      logic byte_select_a;
      logic action_sel_hi;
      logic action_sel_lo;
      logic prog_voltage;
   } pins_t;

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] ext;
   } fuse_set_t;

   typedef enum logic [1:0] {E_OFF, E_GUARD, E_ON, E_FAIL} entry_t;
   typedef enum logic [1:0] {O_IDLE, O_BUSY, O_CLRMEM, O_CLRLOCK} op_t;
   typedef enum logic [2:0] {K_ERASE, K_FLASH, K_EE, K_FUSE_LO, K_FUSE_HI,
                             K_FUSE_EXT, K_LOCK} kind_t;
endpackage

// [logic/parallel_nvm_programming_port.sv]
// Parallel programming port: pin capture, mode entry, page buffers, self-timed writes.
// Assumes load_strobe is the programmer's strobe and all other pins are asynchronous.
`timescale 1ns/1ps
module parallel_nvm_programming_port #(
   parameter int         FLASH_AW     = 16,
   parameter int         PAGE_W       = 7,
   parameter int         EE_AW        = 12,
   parameter int         EE_PAGE_W    = 3,
   parameter int         WRITE_CYCLES = nvm_port_pkg::WRITE_CYC,
   parameter int         ERASE_CYCLES = nvm_port_pkg::ERASE_CYC,
   parameter logic [7:0] FUSE_HI_RST  = 8'hFF,
   parameter logic [7:0] FUSE_EXT_RST = 8'hFF
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   input  wire logic                  load_strobe,
   input  wire logic [7:0]            data_in,
   input  wire nvm_port_pkg::pins_t   pins,
   output logic [7:0]                 data_out,
   output logic                       data_oe,
   output logic                       ready_flag,
   output logic                       prog_mode,
   output nvm_port_pkg::fuse_set_t    fuses,
   output logic [7:0]                 lock_bits
);
   import nvm_port_pkg::*;

   // Link domain: capture on each strobe rise, announce by toggle
   load_word_t cap_q;
   logic       tgl_q;

   always_ff @(posedge load_strobe or negedge reset_n) begin
      if (!reset_n) begin
         cap_q <= '0;
         tgl_q <= 1'b0;
      end else begin
         cap_q <= '{action: {pins.action_sel_hi, pins.action_sel_lo},
                    bsa: pins.byte_select_a, data: data_in};
         tgl_q <= ~tgl_q;
      end
   end

   // Reference domain synchronisers
   // Pin stages reset high, so no write fall or latch rise is seen at release
   pins_t p1_q, p2_q, p3_q;
   logic  t1_q, t2_q, t3_q;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         p1_q <= '1;
         p2_q <= '1;
         p3_q <= '1;
         t1_q <= 1'b0;
         t2_q <= 1'b0;
         t3_q <= 1'b0;
      end else if (clk_en) begin
         p1_q <= pins;
         p2_q <= p1_q;
         p3_q <= p2_q;
         t1_q <= tgl_q;
         t2_q <= t1_q;
         t3_q <= t2_q;
      end
   end

   // cap_q is stable for many cycles around a toggle, so it is read directly
   wire       ld_ev   = t2_q ^ t3_q;
   wire       wr_fall = p3_q.wr_n & ~p2_q.wr_n;
   wire       pl_rise = ~p3_q.page_latch_strobe & p2_q.page_latch_strobe;
   wire       pv_rise = ~p3_q.prog_voltage & p2_q.prog_voltage;
   wire       pv_on   = p2_q.prog_voltage;
   wire [3:0] straps  = {p2_q.page_latch_strobe, p2_q.action_sel_hi,
                         p2_q.action_sel_lo, p2_q.byte_select_a};

   // Mode entry
   entry_t     ent_q;
   logic [2:0] ntog_q;
   logic [7:0] guard_q;
   wire        on = (ent_q == E_ON);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ent_q   <= E_OFF;
         ntog_q  <= '0;
         guard_q <= '0;
      end else if (clk_en) begin
         case (ent_q)
            E_OFF: begin
               if (ld_ev && ntog_q != ENTRY_TOGGLES) begin
                  ntog_q <= ntog_q + 3'h1;
               end
               if (pv_rise) begin
                  if (straps == STRAPS_ENTRY && ntog_q == ENTRY_TOGGLES) begin
                     ent_q   <= E_GUARD;
                     guard_q <= 8'(STRAP_HOLD_CYC - 1);
                  end else begin
                     ent_q <= E_FAIL;
                  end
               end
            end
            E_GUARD: begin
               if (!pv_on) begin
                  ent_q <= E_OFF;
               end else if (straps != STRAPS_ENTRY) begin
                  ent_q <= E_FAIL;
               end else if (guard_q == 8'h00) begin
                  ent_q <= E_ON;
               end else begin
                  guard_q <= guard_q - 8'h01;
               end
            end
            default: begin
               // Leaving the voltage also forgets the counted strobes
               if (!pv_on) begin
                  ent_q  <= E_OFF;
                  ntog_q <= '0;
               end
            end
         endcase
      end
   end

   // Loads of command, address and data
   logic [7:0]  cmd_q, dlo_q, dhi_q;
   logic [15:0] addr_q;
   logic        armed_q;

   wire ld_cmd = ld_ev & on & (cap_q.action == ACT_CMD) & ~cap_q.bsa;
   wire ld_adr = ld_ev & on & (cap_q.action == ACT_ADDR);
   wire ld_dat = ld_ev & on & (cap_q.action == ACT_DATA);
   wire is_wr  = (cap_q.data == CMD_WR_FLASH) | (cap_q.data == CMD_WR_EE);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q   <= CMD_NOP;
         addr_q  <= '0;
         dlo_q   <= '0;
         dhi_q   <= '0;
         armed_q <= 1'b0;
      end else if (clk_en) begin
         if (ld_cmd) begin
            cmd_q   <= cap_q.data;
            armed_q <= is_wr;
         end
         if (ld_adr && cap_q.bsa) begin
            addr_q[15:8] <= cap_q.data;
         end
         if (ld_adr && !cap_q.bsa) begin
            addr_q[7:0] <= cap_q.data;
         end
         if (ld_dat && cap_q.bsa) begin
            dhi_q <= cap_q.data;
         end
         if (ld_dat && !cap_q.bsa) begin
            dlo_q <= cap_q.data;
         end
      end
   end

   // Page buffers
   logic [15:0] pbuf_q [2**PAGE_W];
   logic [7:0]  ebuf_q [2**EE_PAGE_W];

   wire pl_go = pl_rise & on & p2_q.byte_select_a & armed_q;
   wire [PAGE_W-1:0]    pword = addr_q[PAGE_W-1:0];
   wire [EE_PAGE_W-1:0] eword = addr_q[EE_PAGE_W-1:0];

   // Operation start and kind
   op_t        op_q, op_d;
   kind_t      kind_q, kind_d;
   logic [31:0] tmr_q;

   wire bsa    = p2_q.byte_select_a;
   wire bsb    = p2_q.byte_select_b;
   wire wr_go  = wr_fall & on & (op_q == O_IDLE);
   wire st_er  = wr_go & ~bsa & (cmd_q == CMD_ERASE);
   wire st_fl  = wr_go & ~bsa & armed_q & (cmd_q == CMD_WR_FLASH);
   wire st_ee  = wr_go & ~bsa & armed_q & (cmd_q == CMD_WR_EE);
   wire st_fu  = wr_go & ~(bsa & bsb) & (cmd_q == CMD_WR_FUSE);
   wire st_lk  = wr_go & (cmd_q == CMD_WR_LOCK);
   wire go_any = st_er | st_fl | st_ee | st_fu | st_lk;
   wire done   = (op_q == O_BUSY) & (tmr_q == 32'h0);

   assign kind_d = st_er ? K_ERASE :
                   st_fl ? K_FLASH :
                   st_ee ? K_EE :
                   st_lk ? K_LOCK :
                   bsa   ? K_FUSE_HI :
                   bsb   ? K_FUSE_EXT : K_FUSE_LO;

   wire [31:0] tmr_load = st_er ? 32'(ERASE_CYCLES - 1) : 32'(WRITE_CYCLES - 1);
   wire keep_ee = ~fuses.hi[KEEP_EE_BIT];
   wire [FLASH_AW-PAGE_W-1:0] fpage = addr_q[FLASH_AW-1:PAGE_W];
   wire [EE_AW-EE_PAGE_W-1:0] epage = addr_q[EE_AW-1:EE_PAGE_W];
   logic [FLASH_AW-PAGE_W-1:0] fpage_q;
   logic [EE_AW-EE_PAGE_W-1:0] epage_q;

   always_comb begin
      op_d = op_q;
      case (op_q)
         O_IDLE:    op_d = go_any ? O_BUSY : O_IDLE;
         O_BUSY:    op_d = !done ? O_BUSY : (kind_q == K_ERASE) ? O_CLRMEM : O_IDLE;
         O_CLRMEM:  op_d = O_CLRLOCK;
         O_CLRLOCK: op_d = O_IDLE;
         default:   op_d = O_IDLE;
      endcase
   end

   // Target page is frozen at the strobe so later loads cannot redirect it
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_q    <= O_IDLE;
         kind_q  <= K_ERASE;
         tmr_q   <= '0;
         fpage_q <= '0;
         epage_q <= '0;
      end else if (clk_en) begin
         op_q <= op_d;
         if (go_any) begin
            kind_q  <= kind_d;
            tmr_q   <= tmr_load;
            fpage_q <= fpage;
            epage_q <= epage;
         end else if (op_q == O_BUSY && tmr_q != 32'h0) begin
            tmr_q <= tmr_q - 32'h1;
         end
      end
   end

   // Fuses and lock bits
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fuses     <= '{lo: FUSE_LO_RST, hi: FUSE_HI_RST, ext: FUSE_EXT_RST};
         lock_bits <= LOCK_RST;
      end else if (clk_en) begin
         if (done && kind_q == K_FUSE_LO) begin
            fuses.lo <= dlo_q;
         end
         if (done && kind_q == K_FUSE_HI) begin
            fuses.hi <= dlo_q;
         end
         if (done && kind_q == K_FUSE_EXT) begin
            fuses.ext <= dlo_q;
         end
         if (done && kind_q == K_LOCK) begin
            lock_bits <= lock_bits & dlo_q;
         end
         if (op_q == O_CLRLOCK) begin
            lock_bits <= LOCK_RST;
         end
      end
   end

   // Arrays are nonvolatile and therefore have no reset
   logic [15:0] flash_q [2**FLASH_AW];
   logic [7:0]  ee_q    [2**EE_AW];

   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         if (pl_go && cmd_q == CMD_WR_FLASH) begin
            pbuf_q[pword] <= {dhi_q, dlo_q};
         end
         if (pl_go && cmd_q == CMD_WR_EE) begin
            ebuf_q[eword] <= dlo_q;
         end
         if (done && kind_q == K_FLASH) begin
            for (int i = 0; i < 2**PAGE_W; i++) begin
               flash_q[{fpage_q, PAGE_W'(i)}] <= pbuf_q[i];
            end
         end
         if (done && kind_q == K_EE) begin
            for (int i = 0; i < 2**EE_PAGE_W; i++) begin
               ee_q[{epage_q, EE_PAGE_W'(i)}] <= ebuf_q[i];
            end
         end
         if (op_q == O_CLRMEM) begin
            for (int i = 0; i < 2**FLASH_AW; i++) begin
               flash_q[i] <= {ERASED_BYTE, ERASED_BYTE};
            end
            for (int i = 0; i < 2**EE_AW; i++) begin
               if (!keep_ee) begin
                  ee_q[i] <= ERASED_BYTE;
               end
            end
         end
      end
   end

   // Read path
   wire [15:0] fword  = flash_q[addr_q[FLASH_AW-1:0]];
   wire [7:0]  ebyte  = ee_q[addr_q[EE_AW-1:0]];
   wire [7:0]  fu_rd  = ({bsb, bsa} == 2'h0) ? fuses.lo :
                        ({bsb, bsa} == 2'h3) ? fuses.hi :
                        ({bsb, bsa} == 2'h2) ? fuses.ext : lock_bits;
   wire [7:0]  rd_d   = (cmd_q == CMD_RD_FLASH) ? (bsa ? fword[15:8] : fword[7:0]) :
                        (cmd_q == CMD_RD_EE)    ? ebyte :
                        (cmd_q == CMD_RD_FUSE)  ? fu_rd : ERASED_BYTE;
   wire        oe_d   = on & ~p2_q.oe_n;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out   <= '0;
         data_oe    <= 1'b0;
         ready_flag <= 1'b1;
         prog_mode  <= 1'b0;
      end else if (clk_en) begin
         data_out   <= rd_d;
         data_oe    <= oe_d;
         ready_flag <= (op_d == O_IDLE);
         prog_mode  <= (ent_q == E_ON);
      end
   end

   // Checks
   chk_write_busy: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (st_fl || st_ee) |=> !ready_flag && op_q == O_BUSY)
      else $error("page write did not drop ready");

   chk_erase_busy: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      st_er |=> !ready_flag && kind_q == K_ERASE)
      else $error("chip erase did not drop ready");

   chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (op_q == O_BUSY && wr_fall) |=> $stable(kind_q) && $stable(fpage_q))
      else $error("write strobe accepted while busy");

   chk_cmd_keep: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      !ld_cmd |=> $stable(cmd_q))
      else $error("command changed without a load");

   chk_addr_hi_hold: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      !(ld_adr && cap_q.bsa) |=> $stable(addr_q[15:8]))
      else $error("address high byte changed without a load");

   chk_lock_after_mem: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      op_q == O_CLRMEM |=> op_q == O_CLRLOCK ##1 lock_bits == LOCK_RST)
      else $error("lock bits not cleared after memory erase");

   chk_keep_eeprom: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (op_q == O_CLRMEM && keep_ee) |=> $stable(ebyte))
      else $error("eeprom touched with keep fuse set");

   chk_strap_refuse: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (ent_q == E_GUARD && pv_on && straps != STRAPS_ENTRY) |=> ent_q == E_FAIL)
      else $error("strap change did not refuse entry");

   chk_mode_exit: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (!pv_on && ent_q != E_OFF) |=> ent_q == E_OFF ##1 !prog_mode)
      else $error("mode kept after voltage removed");

   chk_nop_disarm: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (ld_cmd && cap_q.data == CMD_NOP) |=> !armed_q ##1 !pl_go)
      else $error("no-op did not end page writing");

   // Ready is a registered copy of the idle state, never a separate flag
   chk_ready_level: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      ready_flag == (op_q == O_IDLE))
      else $error("ready flag disagrees with busy state");

   chk_fuse_target: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (st_fu && bsb && !bsa) |=> kind_q == K_FUSE_EXT)
      else $error("extended fuse write went to wrong byte");

   chk_addr_lo_load: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (ld_adr && !cap_q.bsa) |=> addr_q[7:0] == $past(cap_q.data))
      else $error("address low byte not loaded");

   chk_data_hi_load: assert property (@(posedge ref_clk) disable iff (!reset_n || !clk_en)
      (ld_dat && cap_q.bsa) |=> dhi_q == $past(cap_q.data))
      else $error("data high byte not loaded");
endmodule

// [testbench/nvm_programmer.sv]
// Programmer model: drives the load strobe, data bus and control pins.
// Assumes ref_clk is the device clock; pin changes follow its rising edge.
`timescale 1ns/1ps
module nvm_programmer (
   input  wire logic          ref_clk,
   output logic               load_strobe,
   output logic [7:0]         data_in,
   output nvm_port_pkg::pins_t pins
);
   import nvm_port_pkg::*;
   initial begin
      load_strobe = 1'b0;
      data_in     = 8'h00;
      pins        = '0;
      pins.oe_n   = 1'b1;
      pins.wr_n   = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // One period of the 15 ns link clock; it rests low between frames
   task automatic pulse();
      load_strobe = 1'b1;
      #7.5;
      load_strobe = 1'b0;
      #7.5;
   endtask
   task automatic enter(input logic bad);
      pins.prog_voltage = 1'b0;
      step(4);
      repeat (6) pulse();
      step(1);
      {pins.page_latch_strobe, pins.action_sel_hi, pins.action_sel_lo,
       pins.byte_select_a} = STRAPS_ENTRY;
      step(12);
      pins.prog_voltage = 1'b1;
      if (bad) begin
         step(3);
         pins.byte_select_a = 1'b1;
      end
      step(30);
   endtask
   task automatic load(input logic [1:0] act, input logic bsa, input logic [7:0] d);
      pins.oe_n = 1'b1;
      {pins.action_sel_hi, pins.action_sel_lo} = act;
      pins.byte_select_a = bsa;
      data_in = d;
      step(8);
      pulse();
      step(8);
      // Released bus must not keep showing the byte
      data_in = ~d;
      {pins.action_sel_hi, pins.action_sel_lo} = 2'h3;
      step(30);
   endtask
   task automatic latch();
      pins.byte_select_a = 1'b1;
      step(8);
      pins.page_latch_strobe = 1'b1;
      step(16);
      pins.page_latch_strobe = 1'b0;
      step(8);
   endtask
   task automatic write(input logic bsb, input logic bsa);
      pins.byte_select_b = bsb;
      pins.byte_select_a = bsa;
      step(8);
      pins.wr_n = 1'b0;
      step(16);
      pins.wr_n = 1'b1;
   endtask
   task automatic read(input logic bsb, input logic bsa);
      pins.byte_select_b = bsb;
      pins.byte_select_a = bsa;
      pins.oe_n = 1'b0;
      step(8);
   endtask
endmodule

// [testbench/test_parallel_nvm_programming_port.sv]
// Self-checking bench for the parallel programming port.
// Assumes nvm_programmer drives all pins; clk_en drops only in the freeze check.
`timescale 1ns/1ps
module test_parallel_nvm_programming_port;
   import nvm_port_pkg::*;
   logic       ref_clk;
   logic       reset_n;
   logic       clk_en;
   logic       load_strobe;
   logic [7:0] data_in;
   pins_t      pins;
   logic [7:0] data_out;
   logic       data_oe;
   logic       ready_flag;
   logic       prog_mode;
   fuse_set_t  fuses;
   logic [7:0] lock_bits;
   int         n_fail = 0;
   int         cmp_count = 0;
   // Short self-timed steps keep the run small
   localparam int WR_CYC = 20;
   localparam int ER_CYC = 40;
   parallel_nvm_programming_port #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .load_strobe(load_strobe),
      .data_in(data_in), .pins(pins), .data_out(data_out), .data_oe(data_oe),
      .ready_flag(ready_flag), .prog_mode(prog_mode), .fuses(fuses),
      .lock_bits(lock_bits));
   nvm_programmer prog (
      .ref_clk(ref_clk), .load_strobe(load_strobe), .data_in(data_in), .pins(pins));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      chk("ready_busy", ready_flag, 1'b0);
      while (ready_flag !== 1'b1 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      #1;
      chk("ready_done", ready_flag, 1'b1);
   endtask
   // Command, data low byte, write strobe, then wait for the self-timed step
   task automatic op(input logic [7:0] cmd, input logic [7:0] d, input logic bsb,
                     input logic bsa, input int lim);
      prog.load(ACT_CMD, 1'b0, cmd);
      prog.load(ACT_DATA, 1'b0, d);
      prog.write(bsb, bsa);
      wait_ready(lim);
   endtask
   task automatic look(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo,
                       input logic bsa, input logic [7:0] exp);
      prog.load(ACT_CMD, 1'b0, cmd);
      prog.load(ACT_ADDR, 1'b1, hi);
      prog.load(ACT_ADDR, 1'b0, lo);
      prog.read(1'b0, bsa);
      chk("read_oe", data_oe, 1'b1);
      chk("read_byte", data_out, exp);
   endtask
   task automatic t_reset();
      chk("rst_ready", ready_flag, 1'b1);
      chk("rst_mode", prog_mode, 1'b0);
      chk("rst_lock", lock_bits, LOCK_RST);
   endtask
   task automatic t_entry();
      prog.enter(1'b1);
      chk("mode_refused", prog_mode, 1'b0);
      prog.enter(1'b0);
      chk("mode_on", prog_mode, 1'b1);
      prog.pins.prog_voltage = 1'b0;
      prog.step(10);
      chk("mode_left", prog_mode, 1'b0);
      prog.enter(1'b0);
      chk("mode_again", prog_mode, 1'b1);
   endtask
   task automatic t_flash();
      prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
      prog.load(ACT_ADDR, 1'b1, 8'h02);
      for (int w = 0; w < 2; w++) begin
         prog.load(ACT_ADDR, 1'b0, 8'h05 + w[7:0]);
         prog.load(ACT_DATA, 1'b0, 8'h30 + w[7:0]);
         prog.load(ACT_DATA, 1'b1, 8'hC0 + w[7:0]);
         prog.latch();
      end
      prog.write(1'b0, 1'b0);
      wait_ready(60);
      look(CMD_RD_FLASH, 8'h02, 8'h05, 1'b0, 8'h30);
      prog.read(1'b0, 1'b1);
      chk("flash_hi", data_out, 8'hC0);
      // Command and high address stay loaded
      prog.load(ACT_ADDR, 1'b0, 8'h06);
      prog.read(1'b0, 1'b1);
      chk("flash_kept", data_out, 8'hC1);
      // With clk_en low the read byte must not follow select A
      clk_en = 1'b0;
      prog.read(1'b0, 1'b0);
      chk("freeze_byte", data_out, 8'hC1);
      clk_en = 1'b1;
      prog.read(1'b0, 1'b0);
      chk("thaw_byte", data_out, 8'h31);
   endtask
   task automatic t_eeprom();
      prog.load(ACT_CMD, 1'b0, CMD_WR_EE);
      prog.load(ACT_ADDR, 1'b1, 8'h03);
      prog.load(ACT_ADDR, 1'b0, 8'h12);
      prog.load(ACT_DATA, 1'b0, 8'h5A);
      prog.latch();
      prog.write(1'b0, 1'b0);
      wait_ready(60);
      look(CMD_RD_EE, 8'h03, 8'h12, 1'b0, 8'h5A);
   endtask
   task automatic t_fuse();
      logic [7:0] v [3] = '{8'h90, 8'hF7, 8'hFD};
      logic [1:0] s [3] = '{2'b00, 2'b01, 2'b10};
      fuse_set_t  e;
      e = {FUSE_LO_RST, 8'hFF, 8'hFF};
      for (int i = 0; i < 3; i++) begin
         op(CMD_WR_FUSE, v[i], s[i][1], s[i][0], 60);
         e[23 - 8 * i -: 8] = v[i];
         chk("fuse_set", fuses, e);
      end
   endtask
   task automatic t_erase();
      fuse_set_t f;
      op(CMD_WR_LOCK, 8'hFC, 1'b0, 1'b0, 60);
      chk("lock_set", lock_bits, 8'hFC);
      f = fuses;
      op(CMD_ERASE, 8'h00, 1'b0, 1'b0, 90);
      chk("lock_clr", lock_bits, LOCK_RST);
      chk("fuse_kept", fuses, f);
      look(CMD_RD_FLASH, 8'h02, 8'h05, 1'b0, ERASED_BYTE);
      look(CMD_RD_EE, 8'h03, 8'h12, 1'b0, 8'h5A);
      op(CMD_WR_FUSE, 8'hFF, 1'b0, 1'b1, 60);
      op(CMD_ERASE, 8'h00, 1'b0, 1'b0, 90);
      look(CMD_RD_EE, 8'h03, 8'h12, 1'b0, ERASED_BYTE);
   endtask
   // A second strobe inside the erase must not restart its timer
   task automatic t_busy();
      prog.load(ACT_CMD, 1'b0, CMD_ERASE);
      prog.write(1'b0, 1'b0);
      prog.write(1'b0, 1'b0);
      wait_ready(10);
   endtask
   task automatic t_nop();
      prog.load(ACT_CMD, 1'b0, CMD_NOP);
      prog.write(1'b0, 1'b0);
      chk("nop_idle", ready_flag, 1'b1);
   endtask
   initial begin
      reset_n = 1'b0;
      clk_en  = 1'b1;
      repeat (12) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      t_reset();
      t_entry();
      t_flash();
      t_eeprom();
      t_fuse();
      t_erase();
      t_busy();
      t_nop();
      close_out();
   end
   // Whole run is well under 10000 cycles
   initial begin
      #400us;
      n_fail++;
      close_out();
   end
endmodule
